// *** shared/fbg_defines.svh ***
// Register offsets, field positions and reset values of the fractional baud rate generator.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef FBG_DEFINES_SVH
`define FBG_DEFINES_SVH

`define FBG_ADDR_W        4
`define FBG_OFF_DIVIDER   4'h0
`define FBG_OFF_CONTROL   4'h4
`define FBG_OFF_STATUS    4'h8
`define FBG_FRAC_LSB      0
`define FBG_FRAC_W        4
`define FBG_INT_LSB       4
`define FBG_INT_W         12
`define FBG_CTL_OVS_BIT   0
`define FBG_CTL_MODE_LSB  1
`define FBG_CTL_MODE_W    2
`define FBG_CTL_EN_BIT    3
`define FBG_DIVIDER_RST   16'h0010
`define FBG_CONTROL_RST   4'h0
`define FBG_UNMAPPED_DATA 32'h00000000

`endif

// *** shared/fbg_pkg.sv ***
// Types shared by the fractional baud rate generator files.
// Assumes fbg_defines.svh is on the include path.
`include "fbg_defines.svh"

package fbg_pkg;

	typedef enum logic [1:0]
	{
		FBG_MODE_STANDARD  = 2'b00,
		FBG_MODE_SMARTCARD = 2'b01,
		FBG_MODE_LIN       = 2'b10,
		FBG_MODE_IRDA      = 2'b11
	} fbg_mode_t;

	typedef struct packed
	{
		logic [`FBG_INT_W-1:0]  int_part;
		logic [`FBG_FRAC_W-1:0] frac_part;
	} fbg_divisor_t;

	typedef struct packed
	{
		logic sample_tick;
		logic baud_tick;
	} fbg_ticks_t;

endpackage : fbg_pkg

// *** design/fbg_tick_counter.sv ***
// One fractional divider: adds step_size per clock against step_limit (sixteenths of a clock here) and emits sample ticks.
// Assumes the divisor is steady except when load pulses, and the divisor is at least one.
`timescale 1ns/10ps
module fbg_tick_counter
	import fbg_pkg::*;
#(
	parameter int ACC_W = 17
)
(
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                enable,
	input  wire logic                load,
	input  wire logic [ACC_W-1:0]    step_limit,
	input  wire logic [ACC_W-1:0]    step_size,
	output logic                     tick
);
	if (ACC_W < 6)
	begin : g_bad_width
		$error("fbg_tick_counter: ACC_W too small");
	end

	typedef struct packed
	{
		logic [ACC_W-1:0] acc;
		logic             tick;
	} fbg_cnt_state_t;

	fbg_cnt_state_t state_r;
	fbg_cnt_state_t state_nxt;

	// The accumulator adds step_size per clock; one tick each time it passes step_limit,
	// which spreads the fractional remainder evenly over successive sample periods.
	always_comb
	begin
		state_nxt      = state_r;
		state_nxt.tick = 1'b0;
		if (load || !enable)
		begin
			state_nxt.acc = '0;
		end
		else if (state_r.acc + step_size >= step_limit)
		begin
			state_nxt.acc  = ACC_W'(state_r.acc + step_size - step_limit);
			state_nxt.tick = 1'b1;
		end
		else
		begin
			state_nxt.acc = ACC_W'(state_r.acc + step_size);
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign tick = state_r.tick;

endmodule : fbg_tick_counter

// *** design/fbg_baud_generator.sv ***
// Fractional baud rate generator with an Avalon-MM register slave.
// Assumes one clock, synchronous active-low reset, and a master that holds requests until waitrequest is low.
//
// Overview of operation
// - One divisor drives shared baud and sample ticks for receiver and transmitter.
// - Standard mode: rate is clock over 8 times (2 minus select) times divisor.
// - Smartcard, LIN, IrDA: rate is clock over 16 times divisor always.
// - Divisor is unsigned fixed point: integer part plus fractional part.
// - At 16x oversampling the fraction is bits three to zero.
// - At 8x only fraction bits two to zero count; software keeps bit three zero.
// - Every divider write reloads the internal baud counters at once.
// - At 16x the fraction counts in sixteenths.
// - At 8x the fraction counts in eighths.
// - Select zero means 16 samples per bit, one means 8.
// - Smartcard, IrDA and LIN modes force the select to zero.
`timescale 1ns/10ps
`include "fbg_defines.svh"
module fbg_baud_generator
	import fbg_pkg::*;
#(
	parameter int ACC_W = 17
)
(
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire logic [`FBG_ADDR_W-1:0]    avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic      [31:0]               avs_readdata,
	output logic                           avs_waitrequest,
	output fbg_ticks_t                     ticks,
	output logic                           oversample_eff
);
	if (ACC_W < `FBG_INT_W + `FBG_FRAC_W + 1)
	begin : g_bad_width
		$error("fbg_baud_generator: ACC_W cannot hold the divisor");
	end

	typedef struct packed
	{
		fbg_divisor_t      baud_divider;
		logic              oversample_select;
		fbg_mode_t         mode;
		logic              enable;
		logic              answered;
		logic              waitrequest;
		logic [31:0]       readdata;
		logic              load;
		logic [3:0]        sample_cnt;
		fbg_ticks_t        ticks;
		logic              ovs_eff;
	} fbg_state_t;

	fbg_state_t state_r;
	fbg_state_t state_nxt;

	logic             raw_tick;
	logic             ovs8;
	logic [ACC_W-1:0] limit;
	logic [15:0]      div_word;
	logic [3:0]       last_sample;
	logic             run;

	// The 8x select only takes effect in standard mode.
	assign ovs8 = state_r.oversample_select && (state_r.mode == FBG_MODE_STANDARD);
	assign div_word = state_r.baud_divider;

	// Limit is the divisor in sixteenths at 8x bit three is ignored and the rest doubles to sixteenths.
	always_comb
	begin
		if (ovs8)
			limit = ACC_W'({div_word[15:4], div_word[2:0], 1'b0});
		else
			limit = ACC_W'(div_word);
	end

	// Sample ticks per bit: 16 or 8, giving clock / (8*(2-sel)*div) or clock / (16*div).
	assign last_sample = ovs8 ? 4'h7 : 4'hF;

	// A divisor below one would tick every clock and overrun the accumulator, so the counter is held off
	// until software writes a usable value.
	assign run = state_r.enable && (limit >= ACC_W'(16));

	fbg_tick_counter #(
		.ACC_W      (ACC_W)
	) u_sample_counter (
		.clock      (clock),
		.rst_n      (rst_n),
		.enable     (run),
		.load       (state_r.load),
		.step_limit (limit),
		.step_size  (ACC_W'(16)),
		.tick       (raw_tick)
	);

	always_comb
	begin
		state_nxt          = state_r;
		state_nxt.load     = 1'b0;
		state_nxt.answered    = 1'b0;
		state_nxt.waitrequest = 1'b1;
		state_nxt.ticks       = '0;
		state_nxt.ovs_eff     = ovs8;

		// The last sample tick of a bit also carries the baud tick.
		if (raw_tick && !state_r.load)
		begin
			state_nxt.ticks.sample_tick = 1'b1;
			if (state_r.sample_cnt >= last_sample)
			begin
				state_nxt.sample_cnt      = 4'h0;
				state_nxt.ticks.baud_tick = 1'b1;
			end
			else
			begin
				state_nxt.sample_cnt = state_r.sample_cnt + 4'h1;
			end
		end
		if (state_r.load || !state_r.enable)
			state_nxt.sample_cnt = 4'h0;

		// Every access is answered one cycle after it appears; waitrequest is high otherwise.
		if ((avs_read || avs_write) && !state_r.answered)
		begin
			state_nxt.answered    = 1'b1;
			state_nxt.waitrequest = 1'b0;
			state_nxt.readdata    = `FBG_UNMAPPED_DATA;
			case (avs_address)
				`FBG_OFF_DIVIDER:
				begin
					if (avs_write)
					begin
						if (avs_byteenable[0])
							state_nxt.baud_divider[7:0] = avs_writedata[7:0];
						if (avs_byteenable[1])
							state_nxt.baud_divider[15:8] = avs_writedata[15:8];
						state_nxt.load = 1'b1;
					end
					state_nxt.readdata = {16'h0000, div_word};
				end
				`FBG_OFF_CONTROL:
				begin
					if (avs_write && avs_byteenable[0])
					begin
						state_nxt.oversample_select = avs_writedata[`FBG_CTL_OVS_BIT];
						state_nxt.mode   = fbg_mode_t'(avs_writedata[`FBG_CTL_MODE_LSB +: `FBG_CTL_MODE_W]);
						state_nxt.enable = avs_writedata[`FBG_CTL_EN_BIT];
						state_nxt.load   = 1'b1;
					end
					state_nxt.readdata = {28'h0000000, state_r.enable, state_r.mode, state_r.oversample_select};
				end
				`FBG_OFF_STATUS:
				begin
					state_nxt.readdata = {27'h0000000, ovs8, state_r.sample_cnt};
				end
				default:
				begin
					state_nxt.readdata = `FBG_UNMAPPED_DATA;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_r                   <= '0;
			state_r.baud_divider      <= `FBG_DIVIDER_RST;
			state_r.oversample_select <= 1'(`FBG_CONTROL_RST);
			state_r.mode              <= FBG_MODE_STANDARD;
			state_r.waitrequest       <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign avs_readdata    = state_r.readdata;
	assign avs_waitrequest = state_r.waitrequest;
	assign ticks           = state_r.ticks;
	assign oversample_eff  = state_r.ovs_eff;

endmodule : fbg_baud_generator

// *** testbench/fbg_checker_assertions.sv ***
// Port checker for the fractional baud rate generator.
// Assumes it is bound to fbg_baud_generator and sees only its ports.
`timescale 1ns/10ps
`include "fbg_defines.svh"
module fbg_checker
	import fbg_pkg::*;
(
	input wire logic                   clock,
	input wire logic                   rst_n,
	input wire logic [`FBG_ADDR_W-1:0] avs_address,
	input wire logic                   avs_read,
	input wire logic                   avs_write,
	input wire logic [31:0]            avs_writedata,
	input wire logic [3:0]             avs_byteenable,
	input wire logic [31:0]            avs_readdata,
	input wire logic                   avs_waitrequest,
	input wire fbg_ticks_t             ticks,
	input wire logic                   oversample_eff
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [4:0] cnt_r;
	logic       seen_r;
	logic [2:0] ctl_r;
	sequence taken_s; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence ctl_wr_s; taken_s ##0 (avs_write && avs_address == 4'h4 && avs_byteenable[0]); endsequence
	// A write restarts the counters, so the bit that straddles it is not judged.
	always_ff @(posedge clock)
	begin
		if (!rst_n || (avs_write && !avs_waitrequest))
		begin
			cnt_r  <= 5'h0;
			seen_r <= 1'b0;
		end
		else if (ticks.baud_tick)
		begin
			cnt_r  <= 5'h0;
			seen_r <= 1'b1;
		end
		else if (ticks.sample_tick)
			cnt_r <= cnt_r + 5'h1;
		if (avs_write && avs_waitrequest)
			ctl_r <= avs_writedata[2:0];
	end
	req_answer_a: assert property (taken_s |=> !avs_waitrequest) else $error("request not answered");
	answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
	idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest) else $error("answer unasked");
	baud_sample_a: assert property (ticks.baud_tick |-> ticks.sample_tick) else $error("lone baud tick");
	baud_pulse_a: assert property (ticks.baud_tick |=> !ticks.baud_tick) else $error("baud tick too long");
	unmapped_zero_a: assert property (taken_s ##0 (avs_read && avs_address > 4'h8) |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	ovs_select_a: assert property (ctl_wr_s |-> ##2 oversample_eff == (ctl_r == 3'h1))
		else $error("wrong effective oversampling");
	samples_bit_a: assert property (ticks.baud_tick && seen_r |-> cnt_r == (oversample_eff ? 5'h7 : 5'hF))
		else $error("wrong samples per bit");
endmodule : fbg_checker
bind fbg_baud_generator fbg_checker u_chk (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ticks(ticks), .oversample_eff(oversample_eff));

// *** testbench/tb_fractional_baud_rate_generator.sv ***
// Self-checking bench for the fractional baud rate generator.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/10ps
module tb_fractional_baud_rate_generator
	import fbg_pkg::*;
;
	logic        clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic        avs_waitrequest, oversample_eff;
	fbg_ticks_t  ticks;
	int          mismatches = 0, comparisons = 0, clks, smp;
	always #25 clock = ~clock;
	fbg_baud_generator dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ticks(ticks), .oversample_eff(oversample_eff));
	task final_report;
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task tmo;
		mismatches++;
		$display("ERROR wait expected end seen hang");
		final_report;
	endtask : tmo
	// Waitrequest and read data are read right after the rising edge, before that edge's updates land.
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 50)
			tmo;
	endtask : bus
	task measure(input int bits);
		int n, b;
		n = 0;
		b = 0;
		clks = 0;
		smp = 0;
		do
		begin
			@(negedge clock);
			n++;
		end
		while (ticks.baud_tick !== 1'b1 && n < 20000);
		while (b < bits && n < 20000)
		begin
			@(negedge clock);
			n++;
			clks++;
			smp += ticks.sample_tick;
			b += ticks.baud_tick;
		end
		if (n >= 20000)
			tmo;
	endtask : measure
	task t_reset;
		bus(1'b0, 4'h0, 32'h0);
		chk("divider", 32'h10, q);
		bus(1'b0, 4'h4, 32'h0);
		chk("control", 32'h0, q);
		bus(1'b0, 4'hC, 32'h0);
		chk("unmapped", 32'h0, q);
	endtask : t_reset
	task t_std16;
		bus(1'b1, 4'h0, 32'h1BC);
		bus(1'b0, 4'h0, 32'h0);
		chk("divider", 32'h1BC, q);
		bus(1'b1, 4'h4, 32'h8);
		measure(4);
		chk("clocks16", 4 * 16'h1BC, clks);
		chk("samples16", 64, smp);
		chk("eff16", 32'h0, oversample_eff);
		bus(1'b1, 4'h0, 32'h330);
		measure(2);
		chk("carry16", 2 * 16 * 51, clks);
	endtask : t_std16
	task t_std8;
		bus(1'b1, 4'h0, 32'h1B6);
		bus(1'b1, 4'h4, 32'h9);
		measure(4);
		chk("clocks8", 4 * (8'h1B * 8 + 6), clks);
		chk("samples8", 32, smp);
		chk("eff8", 32'h1, oversample_eff);
		bus(1'b0, 4'h8, 32'h0);
		chk("status8", 32'h1, q >> 4);
		bus(1'b1, 4'h0, 32'h1BE);
		measure(4);
		chk("fracbit3", 4 * (8'h1B * 8 + 6), clks);
	endtask : t_std8
	task t_modes;
		bus(1'b1, 4'h0, 32'h1B6);
		for (int m = 1; m < 4; m++)
		begin
			bus(1'b1, 4'h4, 32'h9 | (m << 1));
			measure(4);
			chk("clocksmode", 4 * (8'h1B * 16 + 6), clks);
			chk("effmode", 32'h0, oversample_eff);
		end
	endtask : t_modes
	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_reset;
		t_std16;
		t_std8;
		t_modes;
		final_report;
	end
endmodule : tb_fractional_baud_rate_generator
